//--- rtl/scra_defs.svh
// Constants for the serial command register access block
// Function
// - Frame is 16 bits: command 15..12, address 11..8, data 7..0.
// - Every register is eight bits wide, one per frame.
// - A configuration or control write stores the frame's data byte into the addressed register.
// - Read data goes out during the next frame; host sends another.
// - Frames accepted at any time, no pacing beyond chip select.
// - Frame executes only on chip select rising edge.
// - Command 0 answers code 7 and echoes the low 12 bits.
// - Host may check the channel any time by comparing the echo.
// - Command 1 reads the addressed configuration register.
// - Command 2 writes data into the addressed configuration register.
// - Command 3 reads the addressed status register.
// - Command 4 writes the addressed status register, restricted.
// - Command 5 reads the addressed control register.
// - Command 6 writes data into the addressed control register.
// - Three separate banks: configuration, control, status.
// - Status 13 holds fault summary, switches, serial error, supply faults.
// - Status 13 bit 3 is one when a serial fault was seen.
// - Reset loads defaults; status 13 resets to all zeros.
// - Only 16-pulse valid frames run; others discarded, set serial error.
// - Sample input on rising clock, change output on falling, MSB first.
// - Status writes only clear bits unless self test unlock is set.
// - Chip select fall enables output and loads pending response.
`ifndef SCRA_DEFS_SVH
`define SCRA_DEFS_SVH
`define SCRA_FRAME_BITS     16
`define SCRA_CMD_MSB        15
`define SCRA_CMD_LSB        12
`define SCRA_ADDR_MSB       11
`define SCRA_ADDR_LSB       8
`define SCRA_CHECK_RESP     4'h7
`define SCRA_FAULT_ADDR     4'hd
`define SCRA_FAULT_RESET    8'h00
`define SCRA_BIT_SUMMARY    7
`define SCRA_BIT_KEYSW      6
`define SCRA_BIT_PWREN      5
`define SCRA_BIT_BATSW      4
`define SCRA_BIT_SERR       3
`define SCRA_BIT_STB        2
`define SCRA_BIT_OT         1
`define SCRA_BIT_STG        0
`define SCRA_CFG_RESET      128'h0000_0000_53ca_8080_1000_1801_1010_1010
`define SCRA_UNLOCK_ADDR    4'h0
`define SCRA_UNLOCK_BIT     0
`endif

//--- rtl/scra_pkg.sv
// Types for the serial command register access block
`default_nettype none
package scra_pkg;
    typedef enum logic [3:0] {
        SCRA_CMD_CHECK  = 4'h0,
        SCRA_CMD_RDCFG  = 4'h1,
        SCRA_CMD_WRCFG  = 4'h2,
        SCRA_CMD_RDSTAT = 4'h3,
        SCRA_CMD_WRSTAT = 4'h4,
        SCRA_CMD_RDCTL  = 4'h5,
        SCRA_CMD_WRCTL  = 4'h6
    } scra_cmd_type;
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } scra_frame_type;
    typedef struct packed {
        logic       keysw;
        logic       pwren;
        logic       batsw;
        logic       short_to_battery;
        logic       overtemp;
        logic       short_to_ground;
    } scra_fault_in_type;
endpackage
`default_nettype wire

//--- rtl/scra_sync.sv
// Two flip-flop synchroniser for one pin
`default_nettype none
module scra_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pin_in,
    output var  logic pin_out
);
    logic meta_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= 1'b1;
            pin_out <= 1'b1;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- rtl/scra_bank.sv
// Sixteen by eight register bank with registered read
`include "scra_defs.svh"
`default_nettype none
module scra_bank #(
    parameter logic [127:0] RESET_VAL = 128'h0
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_addr,
    output var  logic [7:0] rd_data,
    output logic [127:0]    flat
);
    logic [7:0] mem_q [16];
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_reg
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mem_q[i] <= RESET_VAL[i*8 +: 8];
                end else if (wr_en && wr_addr == 4'(i)) begin
                    mem_q[i] <= wr_data;
                end
            end
            assign flat[i*8 +: 8] = mem_q[i];
        end
    endgenerate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule
`default_nettype wire

//--- rtl/scra_top.sv
// Serial command decoder with configuration, control and status banks
`include "scra_defs.svh"
`default_nettype none
module scra_top
    import scra_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              sclk,
    input  wire logic              chip_select_low_n,
    input  wire logic              sdi,
    output var  logic              sdo,
    output var  logic              sdo_oe,
    input  wire scra_fault_in_type fault_in,
    output var  logic [7:0]        fault_status,
    output logic [127:0]           config_regs,
    output logic [127:0]           control_regs,
    output var  logic              self_test_write_unlock
);
    logic sclk_s, cs_s, sdi_s;
    logic sclk_q, cs_q;
    logic [4:0]  count_q;
    logic [15:0] shift_in_q;
    logic [15:0] shift_out_q;
    logic [15:0] resp_q;
    logic        resp_rd_q;
    logic [11:0] resp_hdr_q;
    logic [1:0]  resp_bank_q;
    logic        exec_q;
    scra_frame_type frame;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic cmd_ok, frame_ok;
    logic [7:0] cfg_rd, ctl_rd, stat_rd;
    logic [7:0] stat_wr_val;
    logic [7:0] fault_hw;

    scra_sync u_sync_sclk (.clk(clk), .resetn(resetn), .pin_in(sclk), .pin_out(sclk_s));
    scra_sync u_sync_cs (.clk(clk), .resetn(resetn), .pin_in(chip_select_low_n),
                         .pin_out(cs_s));
    scra_sync u_sync_sdi (.clk(clk), .resetn(resetn), .pin_in(sdi), .pin_out(sdi_s));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            cs_q   <= cs_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_q && !cs_s;
    assign sclk_fall = !sclk_s && sclk_q && !cs_s;
    assign cs_fall   = !cs_s && cs_q;
    assign cs_rise   = cs_s && !cs_q;

    // Input shifter and pulse counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_in_q <= 16'h0000;
            count_q    <= 5'h00;
        end else if (cs_fall) begin
            count_q <= 5'h00;
        end else if (sclk_rise) begin
            shift_in_q <= {shift_in_q[14:0], sdi_s};
            if (count_q != 5'h1f) begin
                count_q <= count_q + 5'h01;
            end
        end
    end

    assign frame = scra_frame_type'(shift_in_q);
    always_comb begin
        unique case (frame.cmd)
            SCRA_CMD_CHECK, SCRA_CMD_RDCFG, SCRA_CMD_WRCFG, SCRA_CMD_RDSTAT,
            SCRA_CMD_WRSTAT, SCRA_CMD_RDCTL, SCRA_CMD_WRCTL: cmd_ok = 1'b1;
            default: cmd_ok = 1'b0;
        endcase
    end
    assign frame_ok = cs_rise && cmd_ok && count_q == 5'(`SCRA_FRAME_BITS);

    // Three banks; status bank holds only register 13
    scra_bank #(.RESET_VAL(`SCRA_CFG_RESET)) u_cfg (
        .clk(clk), .resetn(resetn),
        .wr_en(frame_ok && frame.cmd == SCRA_CMD_WRCFG),
        .wr_addr(frame.addr), .wr_data(frame.data),
        .rd_addr(resp_hdr_q[3:0]), .rd_data(cfg_rd), .flat(config_regs));
    scra_bank #(.RESET_VAL(128'h0)) u_ctl (
        .clk(clk), .resetn(resetn),
        .wr_en(frame_ok && frame.cmd == SCRA_CMD_WRCTL),
        .wr_addr(frame.addr), .wr_data(frame.data),
        .rd_addr(resp_hdr_q[3:0]), .rd_data(ctl_rd), .flat(control_regs));

    assign self_test_write_unlock = control_regs[`SCRA_UNLOCK_ADDR*8 + `SCRA_UNLOCK_BIT];

    assign fault_hw = {1'b0, fault_in.keysw, fault_in.pwren, fault_in.batsw, 1'b0,
                       fault_in.short_to_battery, fault_in.overtemp, fault_in.short_to_ground};
    always_comb begin
        if (self_test_write_unlock) begin
            stat_wr_val = frame.data;
        end else begin
            stat_wr_val = fault_status & frame.data;
        end
    end

    // Status register 13: hardware sets win over host clears unless self test unlock is set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_status <= `SCRA_FAULT_RESET;
        end else begin
            logic [7:0] nxt;
            nxt = fault_status;
            if (frame_ok && frame.cmd == SCRA_CMD_WRSTAT
                && frame.addr == `SCRA_FAULT_ADDR) begin
                nxt = stat_wr_val;
            end
            if (!self_test_write_unlock) begin
                nxt = nxt | fault_hw;
            end
            if (cs_rise && !frame_ok) begin
                nxt[`SCRA_BIT_SERR] = 1'b1;
            end
            nxt[`SCRA_BIT_SUMMARY] = (|nxt[6:0]) | (nxt[`SCRA_BIT_SUMMARY]
                                     && self_test_write_unlock);
            fault_status <= nxt;
        end
    end
    assign stat_rd = (resp_hdr_q[3:0] == `SCRA_FAULT_ADDR) ? fault_status : 8'h00;

    // Pending response, prepared only by executed frames
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp_rd_q   <= 1'b0;
            resp_hdr_q  <= 12'h000;
            resp_bank_q <= 2'd0;
            resp_q      <= 16'h0000;
            exec_q      <= 1'b0;
        end else begin
            exec_q <= frame_ok;
            if (frame_ok) begin
                resp_rd_q <= 1'b0;
                if (frame.cmd == SCRA_CMD_CHECK) begin
                    resp_q <= {`SCRA_CHECK_RESP, shift_in_q[11:0]};
                end else if (frame.cmd == SCRA_CMD_RDCFG || frame.cmd == SCRA_CMD_RDSTAT
                             || frame.cmd == SCRA_CMD_RDCTL) begin
                    resp_rd_q   <= 1'b1;
                    resp_hdr_q  <= {frame.cmd, 4'h0, frame.addr};
                    resp_bank_q <= (frame.cmd == SCRA_CMD_RDCFG) ? 2'd0 :
                                   (frame.cmd == SCRA_CMD_RDSTAT) ? 2'd1 : 2'd2;
                end else begin
                    resp_q <= shift_in_q;
                end
            end else if (resp_rd_q) begin
                unique case (resp_bank_q)
                    2'd0: resp_q <= {resp_hdr_q[11:8], resp_hdr_q[3:0], cfg_rd};
                    2'd1: resp_q <= {resp_hdr_q[11:8], resp_hdr_q[3:0], stat_rd};
                    default: resp_q <= {resp_hdr_q[11:8], resp_hdr_q[3:0], ctl_rd};
                endcase
            end
        end
    end

    // Output shifter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_out_q <= 16'h0000;
            sdo_oe      <= 1'b0;
            sdo         <= 1'b0;
        end else if (cs_fall) begin
            shift_out_q <= resp_q;
            sdo         <= resp_q[15];
            sdo_oe      <= 1'b1;
        end else if (cs_s) begin
            sdo_oe <= 1'b0;
        end else if (sclk_fall && count_q != 5'h00) begin
            shift_out_q <= {shift_out_q[14:0], 1'b0};
            sdo         <= shift_out_q[14];
        end
    end
endmodule
`default_nettype wire

//--- verification/scra_host_model.sv
// Host side serial master model that sends frames into the block
`default_nettype none
module scra_host_model (
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // Sends n pulses of tx, MSB first, and gathers the reply
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx   = 16'h0000;
        cs_n = 1'b0;
        #125;
        for (int i = 0; i < n; i++) begin
            sdi = tx[15 - i];
            #62.5 sclk = 1'b1;
            rx = {rx[14:0], sdo};
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        // Inverted data line, so it no longer shows the last bit
        sdi = ~sdi;
        #250;
    endtask
endmodule
`default_nettype wire

//--- verification/scra_monitor.sv
// Port checker for the serial command register access block
`default_nettype none
module scra_monitor
    import scra_pkg::*;
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              sclk,
    input wire logic              chip_select_low_n,
    input wire logic              sdi,
    input wire logic              sdo,
    input wire logic              sdo_oe,
    input wire scra_fault_in_type fault_in,
    input wire logic [7:0]        fault_status,
    input wire logic [127:0]      config_regs,
    input wire logic [127:0]      control_regs,
    input wire logic              self_test_write_unlock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    oe_on_a: assert property ($fell(chip_select_low_n) |-> ##[1:5] sdo_oe)
        else $error("output not enabled after select");
    oe_off_a: assert property (chip_select_low_n [*6] |-> !sdo_oe)
        else $error("output enabled while deselected");
    cfg_exec_a: assert property ($changed(config_regs) |->
        $past(chip_select_low_n) && $past(chip_select_low_n, 2))
        else $error("configuration changed inside a frame");
    ctl_exec_a: assert property ($changed(control_regs) |->
        $past(chip_select_low_n) && $past(chip_select_low_n, 2))
        else $error("control changed inside a frame");
    fault_sum_a: assert property (|fault_status[6:0] |-> ##[0:1] fault_status[7])
        else $error("summary flag missing");
    fault_set_a: assert property (fault_in.overtemp && !self_test_write_unlock
        |-> ##[1:2] fault_status[1])
        else $error("overtemperature not latched");
    unlock_mirror_a: assert property ($changed(control_regs[0]) |->
        ##[0:1] self_test_write_unlock == control_regs[0])
        else $error("unlock does not follow control bit");
    status_set_a: assert property ($rose(fault_status[2]) |-> self_test_write_unlock
        || $past(fault_in.short_to_battery) || $past(fault_in.short_to_battery, 2))
        else $error("status bit set without cause");
    cover property ($rose(fault_status[3]));
    cover property ($fell(fault_status[3]));
    cover property ($changed(config_regs));
endmodule
bind scra_top scra_monitor mon (.clk(clk), .resetn(resetn), .sclk(sclk),
    .chip_select_low_n(chip_select_low_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .fault_in(fault_in), .fault_status(fault_status), .config_regs(config_regs),
    .control_regs(control_regs), .self_test_write_unlock(self_test_write_unlock));
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the serial command register access block
`include "scra_defs.svh"
`default_nettype none
module testbench;
    import scra_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk;
    logic              resetn;
    logic              sclk;
    logic              cs_n;
    logic              sdi;
    logic              sdo;
    logic              sdo_oe;
    scra_fault_in_type fault_in;
    logic [7:0]        fault_status;
    logic [127:0]      config_regs;
    logic [127:0]      control_regs;
    logic              unlock;
    logic [15:0]       rx;
    int                failures;
    int                compares;
    localparam logic [127:0] cfg_after_write = (`SCRA_CFG_RESET & ~(128'hff << 72))
                                               | (128'ha5 << 72);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    scra_top dut (.clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_low_n(cs_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .fault_in(fault_in),
        .fault_status(fault_status), .config_regs(config_regs),
        .control_regs(control_regs), .self_test_write_unlock(unlock));
    scra_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_r(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t regs %h expected %h", $time, got, exp);
        end
    endtask
    task automatic f(input logic [15:0] tx);
        host.xfer(tx, 16, rx);
    endtask
    task automatic conclude();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_check();
        f(16'h0abc);
        f(16'h0fff);
        chk_w(rx, 16'h7abc);
        f(16'h0000);
        chk_w(rx, 16'h7fff);
        chk_w({15'h0000, sdo_oe}, 16'h0000);
        $display("check done");
    endtask
    task automatic t_banks();
        logic [3:0] cmd;
        for (int b = 0; b < 2; b++) begin
            cmd = b ? SCRA_CMD_WRCTL : SCRA_CMD_WRCFG;
            f({cmd, 4'h9, 8'ha5});
            f({cmd - 4'h1, 4'h9, 8'h00});
            chk_w(rx, {cmd, 4'h9, 8'ha5});
            f(16'h0000);
            chk_w(rx, {cmd - 4'h1, 4'h9, 8'ha5});
        end
        chk_r(config_regs, cfg_after_write);
        chk_r(control_regs, 128'h00a5 << 72);
        f(16'h3200);
        f(16'h0000);
        chk_w(rx, 16'h3200);
        $display("banks done");
    endtask
    task automatic t_bad();
        f(16'h0123);
        host.xfer(16'h2955, 15, rx);
        f(16'h8000);
        f(16'h0000);
        chk_w(rx, 16'h7123);
        chk_w({8'h00, fault_status}, 16'h0088);
        chk_r(config_regs, cfg_after_write);
        $display("bad frames done");
    endtask
    task automatic t_status();
        f(16'h3d00);
        f(16'h4dff);
        chk_w(rx, 16'h3d88);
        chk_w({8'h00, fault_status}, 16'h0088);
        f(16'h4d00);
        chk_w({8'h00, fault_status}, 16'h0000);
        f(16'h6001);
        chk_w({15'h0000, unlock}, 16'h0001);
        f(16'h4d04);
        chk_w({8'h00, fault_status}, 16'h0084);
        f(16'h6000);
        f(16'h4d00);
        chk_w({8'h00, fault_status}, 16'h0000);
        $display("status done");
    endtask
    task automatic t_fault();
        logic [7:0] exp;
        exp = 8'h80;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) #1 fault_in = 6'h01 << i;
            @(posedge clk) #1 fault_in = '0;
            repeat (3) @(posedge clk);
            exp = exp | (8'h01 << (i < 3 ? i : i + 1));
            chk_w({8'h00, fault_status}, {8'h00, exp});
        end
        $display("fault inputs done");
    endtask
    initial begin
        resetn = 1'b0;
        fault_in = '0;
        failures = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        chk_r(config_regs, `SCRA_CFG_RESET);
        chk_r(control_regs, 128'h0000);
        chk_w({8'h00, fault_status}, 16'h0000);
        t_check();
        t_banks();
        t_bad();
        t_status();
        t_fault();
        conclude();
    end
    // About 22 frames of 2.5 us each; the limit allows more than three times that
    initial begin
        #200000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
